// file: hdl/board_option_setup_regs.sv
// Purpose: option-select registers replacing board configuration switches
// Assumes: host I/O strobes are one-cycle pulses synchronous to clk
// Notes:   cleared by system reset; decodes for serial and parallel ports
`timescale 1ns/1ps
`include "bosr_defs.svh"

////////////////////////////////////////////////////////////////////////////////
module board_option_setup_regs
    import bosr_pkg::*;
#(
    parameter int NUM_SLOTS = 8
) (
    input  wire logic                 clk,
    input  wire logic                 rst_n,
    input  wire logic [15:0]          ioAddr,
    input  wire logic [7:0]           ioWrData,
    input  wire logic                 ioRd,
    input  wire logic                 ioWr,
    output logic      [7:0]           ioRdData,
    output logic                      ioRdValid,
    input  wire logic                 card_select_feedback_n,
    input  wire logic                 extConfigMode,
    input  wire logic                 periphSerialEn,
    input  wire logic                 periphSerialPrim,
    output logic                      floppyEnable,
    output logic                      parallelEnable,
    output logic                      parallelCompat,
    output logic                      parallelBidir,
    output logic      [15:0]          parallelBase,
    output logic                      parallelBaseValid,
    output logic                      parallelSelect,
    output logic                      first_serial_phys_en,
    output logic      [15:0]          first_serial_phys_base,
    output logic      [3:0]           first_serial_phys_irq,
    output logic                      firstSerialSelect,
    output logic                      board_memory_enable,
    output logic                      videoSetup,
    output logic                      boardSetup,
    output logic                      adapterSetup,
    output logic      [NUM_SLOTS-1:0] slotSetupSel,
    output logic                      channelReset,
    output logic                      boardAccess
);

    ////////////////////////////////////////////////////////////////////////////
    // feedback input synchroniser

    logic feedbackSync_n;

    bosr_sync #(
        .RESET_VAL (1'b1)
    ) u_fb_sync (
        .clk     (clk),
        .rst_n   (rst_n),
        .asyncIn (card_select_feedback_n),
        .syncOut (feedbackSync_n)
    );

    ////////////////////////////////////////////////////////////////////////////
    // address decode

    logic selFeedback;
    logic selSetupMode;
    logic selAdapter;
    logic selIdLow;
    logic selIdHigh;
    logic selConfig;
    logic selConfigExt;
    logic anyReg;

    assign selFeedback  = (ioAddr == `BOSR_OFS_FEEDBACK);
    assign selSetupMode = (ioAddr == `BOSR_OFS_SETUP_MODE);
    assign selAdapter   = (ioAddr == `BOSR_OFS_ADAPTER);
    assign selIdLow     = (ioAddr == `BOSR_OFS_ID_LOW);
    assign selIdHigh    = (ioAddr == `BOSR_OFS_ID_HIGH);
    assign selConfig    = (ioAddr == `BOSR_OFS_CONFIG);
    assign selConfigExt = (ioAddr == `BOSR_OFS_CONFIG_EXT);
    assign anyReg       = selFeedback | selSetupMode | selAdapter | selIdLow
                        | selIdHigh | selConfig | selConfigExt;

    ////////////////////////////////////////////////////////////////////////////
    // decoded device configuration

    bosr_state_t   st_q;
    bosr_state_t   st_d;
    bosr_par_sel_t parSel;
    logic          master;
    logic          serEnSrc;
    logic          serPrimSrc;
    logic          serHit;
    logic          parHit;

    assign master = st_q.config0[`BOSR_CFG_MASTER];
    assign floppyEnable   = master & st_q.config0[`BOSR_CFG_FLOPPY];
    assign parallelEnable = master & st_q.config0[`BOSR_CFG_PAR_EN];
    assign parallelCompat = st_q.config0[`BOSR_CFG_PAR_COMPAT];
    assign parallelBidir  = ~st_q.config0[`BOSR_CFG_PAR_COMPAT];
    assign parSel = bosr_par_sel_t'(st_q.config0[`BOSR_CFG_PAR_HI:`BOSR_CFG_PAR_LO]);

    always_comb begin
        parallelBaseValid = 1'b1;
        case (parSel)
            BOSR_PAR_3BC: parallelBase = `BOSR_PAR_BASE_3BC;
            BOSR_PAR_378: parallelBase = `BOSR_PAR_BASE_378;
            BOSR_PAR_278: parallelBase = `BOSR_PAR_BASE_278;
            default: begin
                parallelBase      = 16'h0000;
                parallelBaseValid = 1'b0;
            end
        endcase
    end

    // extended mode takes serial setup from the outside register
    assign serEnSrc   = extConfigMode ? periphSerialEn
                                      : (master & st_q.config0[`BOSR_CFG_SER_EN]);
    assign serPrimSrc = extConfigMode ? periphSerialPrim
                                      : st_q.config0[`BOSR_CFG_SER_PRIM];

    assign first_serial_phys_en   = serEnSrc;
    assign first_serial_phys_base = serPrimSrc ? `BOSR_SER_PRIM_BASE : `BOSR_SER_ALT_BASE;
    assign first_serial_phys_irq  = serPrimSrc ? `BOSR_IRQ_PRIM : `BOSR_IRQ_ALT;

    // eight-byte serial window, four-byte parallel window
    assign serHit = serEnSrc & (ioAddr[15:3] == first_serial_phys_base[15:3]);
    assign parHit = parallelEnable & parallelBaseValid
                  & (ioAddr[15:2] == parallelBase[15:2]);
    assign firstSerialSelect = serHit & (ioRd | ioWr);
    assign parallelSelect    = parHit & (ioRd | ioWr);

    assign board_memory_enable = st_q.configExt[`BOSR_EXT_MEM_EN];

    ////////////////////////////////////////////////////////////////////////////
    // setup mode steering; software keeps these exclusive

    assign videoSetup   = st_q.setupMode[`BOSR_SM_VIDEO];
    assign boardSetup   = ~st_q.setupMode[`BOSR_SM_BOARD];
    assign adapterSetup = st_q.adapterCtl[`BOSR_AD_SETUP];
    assign channelReset = st_q.adapterCtl[`BOSR_AD_RESET];

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SLOTS; gi++) begin : g_slot
            assign slotSetupSel[gi] = adapterSetup
                                    & (st_q.adapterCtl[2:0] == 3'(gi));
        end
    endgenerate

    // any own register or on-board device decode counts as board access
    assign boardAccess = (ioRd | ioWr) & (anyReg | serHit | parHit
                       | (boardSetup & ~selFeedback));

    ////////////////////////////////////////////////////////////////////////////
    // register state

    always_comb begin
        st_d = st_q;
        // feedback bit follows the current cycle, not sticky
        st_d.feedback = ~feedbackSync_n | boardAccess;
        if (ioWr) begin
            if (selSetupMode) begin
                st_d.setupMode = ioWrData;
            end
            if (selAdapter) begin
                st_d.adapterCtl = ioWrData;
            end
            if (selIdLow && !st_q.idLowDone) begin
                st_d.idLow     = ioWrData;
                st_d.idLowDone = 1'b1;
            end
            if (selIdHigh && !st_q.idHighDone) begin
                st_d.idHigh     = ioWrData;
                st_d.idHighDone = 1'b1;
            end
            if (selConfig) begin
                st_d.config0 = ioWrData;
            end
            if (selConfigExt) begin
                st_d.configExt = ioWrData;
            end
        end
        st_d.rdValid  = ioRd & anyReg;
        st_d.readData = 8'h00;
        if (ioRd) begin
            if (selFeedback) begin
                st_d.readData = `BOSR_READ_ONES_0091 | {7'h00, st_q.feedback};
            end else if (selSetupMode) begin
                st_d.readData = st_q.setupMode | `BOSR_READ_ONES_0094;
            end else if (selAdapter) begin
                st_d.readData = st_q.adapterCtl | `BOSR_READ_ONES_0096;
            end else if (selIdLow) begin
                st_d.readData = st_q.idLow;
            end else if (selIdHigh) begin
                st_d.readData = st_q.idHigh;
            end else if (selConfig) begin
                st_d.readData = st_q.config0;
            end else if (selConfigExt) begin
                st_d.readData = st_q.configExt;
            end else begin
                st_d.readData = 8'hFF;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    assign ioRdData  = st_q.readData;
    assign ioRdValid = st_q.rdValid;

endmodule // board_option_setup_regs

// file: hdl/bosr_defs.svh
// Purpose: offsets, field positions, reset values for board option setup registers
// Assumes: byte-wide I/O space, 16-bit I/O address
// Notes:   included by the package and the register bank
`ifndef BOSR_DEFS_SVH
`define BOSR_DEFS_SVH

`define BOSR_OFS_FEEDBACK    16'h0091
`define BOSR_OFS_SETUP_MODE  16'h0094
`define BOSR_OFS_ADAPTER     16'h0096
`define BOSR_OFS_ID_LOW      16'h0100
`define BOSR_OFS_ID_HIGH     16'h0101
`define BOSR_OFS_CONFIG      16'h0102
`define BOSR_OFS_CONFIG_EXT  16'h0103

`define BOSR_CFG_MASTER      0
`define BOSR_CFG_FLOPPY      1
`define BOSR_CFG_SER_EN      2
`define BOSR_CFG_SER_PRIM    3
`define BOSR_CFG_PAR_EN      4
`define BOSR_CFG_PAR_LO      5
`define BOSR_CFG_PAR_HI      6
`define BOSR_CFG_PAR_COMPAT  7
`define BOSR_EXT_MEM_EN      0
`define BOSR_SM_VIDEO        5
`define BOSR_SM_BOARD        7
`define BOSR_AD_SETUP        3
`define BOSR_AD_RESET        7

`define BOSR_RST_BYTE        8'h00
`define BOSR_READ_ONES_0094  8'h5F
`define BOSR_READ_ONES_0096  8'h70
`define BOSR_READ_ONES_0091  8'hFE

`define BOSR_SER_PRIM_BASE   16'h03F8
`define BOSR_SER_ALT_BASE    16'h02F8
`define BOSR_PAR_BASE_3BC    16'h03BC
`define BOSR_PAR_BASE_378    16'h0378
`define BOSR_PAR_BASE_278    16'h0278
`define BOSR_IRQ_PRIM        4'h4
`define BOSR_IRQ_ALT         4'h3

`endif

// file: hdl/bosr_pkg.sv
// Purpose: types for board option setup registers
// Assumes: bosr_defs.svh holds the numbers
// Notes:   state of the bank is one packed struct
package bosr_pkg;
    `include "bosr_defs.svh"

    typedef enum logic [1:0] {
        BOSR_PAR_3BC  = 2'b00,
        BOSR_PAR_378  = 2'b01,
        BOSR_PAR_278  = 2'b10,
        BOSR_PAR_UNDF = 2'b11
    } bosr_par_sel_t;

    typedef enum logic [1:0] {
        BOSR_ID_EMPTY = 2'b00,
        BOSR_ID_HALF  = 2'b01,
        BOSR_ID_FULL  = 2'b10
    } bosr_id_state_t;

    typedef struct packed {
        logic [7:0]      setupMode;
        logic [7:0]      adapterCtl;
        logic [7:0]      idLow;
        logic [7:0]      idHigh;
        logic            idLowDone;
        logic            idHighDone;
        logic [7:0]      config0;
        logic [7:0]      configExt;
        logic            feedback;
        logic [7:0]      readData;
        logic            rdValid;
    } bosr_state_t;
endpackage

// file: hdl/bosr_sync.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes:   output changes only when stages two and three agree
`timescale 1ns/1ps
module bosr_sync #(
    parameter logic RESET_VAL = 1'b1
) (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic asyncIn,
    output logic      syncOut
);
    typedef struct packed {
        logic [2:0] stage;
        logic       out;
    } bosr_sync_state_t;

    bosr_sync_state_t st_q;
    bosr_sync_state_t st_d;

    always_comb begin
        st_d       = st_q;
        // first stage is read only by the second
        st_d.stage = {st_q.stage[1:0], asyncIn};
        if (st_q.stage[1] == st_q.stage[2]) begin
            st_d.out = st_q.stage[2];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= {{3{RESET_VAL}}, RESET_VAL};
        end else begin
            st_q <= st_d;
        end
    end

    assign syncOut = st_q.out;
endmodule // bosr_sync

// file: testbench/bosr_adapter_model.sv
// Purpose: expansion adapter answering in its own I/O window
// Assumes: strobes are one-cycle pulses
// Notes:   released line is driven high once the hold count reaches zero
`timescale 1ns/1ps
module bosr_adapter_model #(
    parameter logic [15:0] BASE = 16'h0300
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [15:0] ioAddr,
    input  wire logic        ioRd,
    input  wire logic        ioWr,
    output logic             card_select_feedback_n
);
    logic [3:0] holdCnt_q;
    // held ten cycles so the three-stage sync sees it
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            holdCnt_q <= 4'h0;
        else if ((ioRd || ioWr) && ioAddr[15:3] == BASE[15:3])
            holdCnt_q <= 4'hA;
        else if (holdCnt_q != 4'h0)
            holdCnt_q <= holdCnt_q - 4'h1;
    end
    assign card_select_feedback_n = (holdCnt_q == 4'h0);
endmodule // bosr_adapter_model

// file: testbench/bosr_regs_props.sv
// Purpose: port checks for board option setup registers
// Assumes: one clock, async active-low reset
// Notes:   read checks use the read-as-one masks of the bank
`timescale 1ns/1ps
module bosr_regs_props #(
    parameter int NUM_SLOTS = 8
) (
    input wire logic                 clk,
    input wire logic                 rst_n,
    input wire logic [15:0]          ioAddr,
    input wire logic                 ioRd,
    input wire logic [7:0]           ioRdData,
    input wire logic                 ioRdValid,
    input wire logic                 parallelCompat,
    input wire logic                 parallelBidir,
    input wire logic                 parallelEnable,
    input wire logic [15:0]          parallelBase,
    input wire logic                 parallelBaseValid,
    input wire logic                 parallelSelect,
    input wire logic                 first_serial_phys_en,
    input wire logic [15:0]          first_serial_phys_base,
    input wire logic [3:0]           first_serial_phys_irq,
    input wire logic                 firstSerialSelect,
    input wire logic                 adapterSetup,
    input wire logic [NUM_SLOTS-1:0] slotSetupSel
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_rd(logic [15:0] a); ioRd && ioAddr == a; endsequence
    property p_par_mode; parallelBidir == !parallelCompat; endproperty
    a_par_mode: assert property (p_par_mode) else $error("parallel mode pair");
    property p_par_base; parallelBaseValid |-> parallelBase inside {16'h03BC, 16'h0378, 16'h0278}; endproperty
    a_par_base: assert property (p_par_base) else $error("parallel base");
    property p_par_sel; parallelSelect |-> parallelEnable && ioAddr[15:2] == parallelBase[15:2]; endproperty
    a_par_sel: assert property (p_par_sel) else $error("parallel select");
    property p_ser_irq; first_serial_phys_irq == (first_serial_phys_base == 16'h03F8 ? 4'h4 : 4'h3); endproperty
    a_ser_irq: assert property (p_ser_irq) else $error("serial irq");
    property p_ser_sel; firstSerialSelect |-> first_serial_phys_en && ioAddr[15:3] == first_serial_phys_base[15:3];
    endproperty
    a_ser_sel: assert property (p_ser_sel) else $error("serial select");
    property p_rd91; s_rd(16'h0091) |=> ioRdValid && ioRdData[7:1] == 7'h7F; endproperty
    a_rd91: assert property (p_rd91) else $error("feedback read");
    property p_rd94; s_rd(16'h0094) |=> ioRdValid && (ioRdData & 8'h5F) == 8'h5F; endproperty
    a_rd94: assert property (p_rd94) else $error("setup mode read");
    property p_rd96; s_rd(16'h0096) |=> ioRdValid && (ioRdData & 8'h70) == 8'h70; endproperty
    a_rd96: assert property (p_rd96) else $error("adapter control read");
    property p_slot; slotSetupSel != '0 |-> adapterSetup && $onehot(slotSetupSel); endproperty
    a_slot: assert property (p_slot) else $error("slot select");
endmodule // bosr_regs_props
////////////////////////////////////////////////////////////////////////////////
bind board_option_setup_regs bosr_regs_props #(.NUM_SLOTS(NUM_SLOTS)) i_props (.clk, .rst_n, .ioAddr, .ioRd,
    .ioRdData, .ioRdValid, .parallelCompat, .parallelBidir, .parallelEnable, .parallelBase, .parallelBaseValid,
    .parallelSelect, .first_serial_phys_en, .first_serial_phys_base, .first_serial_phys_irq, .firstSerialSelect,
    .adapterSetup, .slotSetupSel);

// file: testbench/testbench.sv
// Purpose: directed bench for board option setup registers
// Assumes: adapter model sits at 0300
// Notes:   one task per scenario
`timescale 1ns/1ps
module testbench;
    import bosr_pkg::*;
    logic clk, rst_n, ioRd, ioWr, extConfigMode, periphSerialEn, periphSerialPrim, rv;
    logic ioRdValid, card_select_feedback_n, floppyEnable, parallelEnable, parallelCompat, parallelBidir;
    logic parallelBaseValid, parallelSelect, first_serial_phys_en, firstSerialSelect, board_memory_enable;
    logic videoSetup, boardSetup, adapterSetup, channelReset, boardAccess;
    logic [15:0] ioAddr, parallelBase, first_serial_phys_base;
    logic [7:0]  ioWrData, ioRdData, slotSetupSel, rd;
    logic [3:0]  first_serial_phys_irq;
    int          miscompares = 0;
    int          nCompared = 0;
    board_option_setup_regs #(.NUM_SLOTS(8)) i_board_option_setup_regs (.clk, .rst_n, .ioAddr, .ioWrData, .ioRd,
        .ioWr, .ioRdData, .ioRdValid, .card_select_feedback_n, .extConfigMode, .periphSerialEn, .periphSerialPrim,
        .floppyEnable, .parallelEnable, .parallelCompat, .parallelBidir, .parallelBase, .parallelBaseValid,
        .parallelSelect, .first_serial_phys_en, .first_serial_phys_base, .first_serial_phys_irq, .firstSerialSelect,
        .board_memory_enable, .videoSetup, .boardSetup, .adapterSetup, .slotSetupSel, .channelReset, .boardAccess);
    bosr_adapter_model i_bosr_adapter_model (.clk, .rst_n, .ioAddr, .ioRd, .ioWr, .card_select_feedback_n);
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        nCompared++;
        if (s !== e) begin
            $display("wrong value %s expected %h seen %h", n, e, s);
            miscompares++;
        end
    endtask
    task automatic conclude();
        if (miscompares == 0 && nCompared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // one-cycle strobe; read data lands the cycle after
    task automatic io(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        #1;
        {ioAddr, ioWrData, ioWr, ioRd} = {a, d, w, !w};
        @(posedge clk);
        #1;
        {ioWr, ioRd, rd, rv} = {2'b00, ioRdData, ioRdValid};
    endtask
    task automatic t_reset();
        io(0, 16'h0094, 8'h00);
        chk("setup mode", rd, 8'h5F);
        io(0, 16'h0096, 8'h00);
        chk("adapter ctl", rd, 8'h70);
        chk("board setup", boardSetup, 1'b1);
    endtask
    task automatic t_id();
        for (int i = 0; i < 2; i++) begin
            io(1, 16'h0100 + 16'(i), 8'hA5);
            io(1, 16'h0100 + 16'(i), 8'h3C);
            io(0, 16'h0100 + 16'(i), 8'h00);
            chk("system id", rd, 8'hA5);
        end
    endtask
    task automatic t_cfg();
        logic [15:0] base [4] = '{16'h03BC, 16'h0378, 16'h0278, 16'h0000};
        logic [1:0] b;
        io(1, 16'h0102, 8'hDE);
        chk("gated enables", {floppyEnable, parallelEnable, first_serial_phys_en}, 3'b000);
        for (int k = 0; k < 4; k++) begin
            b = k[1:0];
            io(1, 16'h0102, {b[0], b, 1'b1, b[0], 3'b111});
            chk("compat", {parallelCompat, parallelBidir}, {b[0], !b[0]});
            chk("par base", {parallelBase, parallelBaseValid}, {base[b], b != 2'b11});
            chk("ser base", first_serial_phys_base, b[0] ? 16'h03F8 : 16'h02F8);
            chk("ser irq", first_serial_phys_irq, b[0] ? 4'h4 : 4'h3);
            chk("enables", {floppyEnable, parallelEnable, first_serial_phys_en}, 3'b111);
        end
        io(1, 16'h0102, 8'h3F);
        @(posedge clk);
        #1;
        {ioAddr, ioRd} = {16'h037A, 1'b1};
        #2;
        chk("par select", {parallelSelect, firstSerialSelect}, 2'b10);
        chk("par access", boardAccess, 1'b1);
        @(posedge clk);
        #1;
        ioRd = 1'b0;
        @(posedge clk);
        #1;
        {ioAddr, ioRd} = {16'h03FD, 1'b1};
        #2;
        chk("ser select", {firstSerialSelect, parallelSelect}, 2'b10);
        @(posedge clk);
        #1;
        ioRd = 1'b0;
    endtask
    task automatic t_ext();
        io(1, 16'h0102, 8'h01);
        @(posedge clk);
        #1;
        {extConfigMode, periphSerialEn, periphSerialPrim} = 3'b111;
        #2;
        chk("ext ser", {first_serial_phys_en, first_serial_phys_base}, {1'b1, 16'h03F8});
        @(posedge clk);
        #1;
        periphSerialPrim = 1'b0;
        #2;
        chk("ext alt", first_serial_phys_irq, 4'h3);
        @(posedge clk);
        #1;
        extConfigMode = 1'b0;
        #2;
        chk("own ser", first_serial_phys_en, 1'b0);
    endtask
    task automatic t_setup();
        io(1, 16'h0094, 8'h80);
        // one setup category at a time from here on
        io(1, 16'h0096, 8'h8B);
        chk("adapter", {adapterSetup, slotSetupSel, channelReset}, {1'b1, 8'h08, 1'b1});
        io(0, 16'h0096, 8'h00);
        chk("adapter rd", rd, 8'hFB);
        io(1, 16'h0096, 8'h00);
        io(1, 16'h0094, 8'hA0);
        chk("video", {videoSetup, boardSetup}, 2'b10);
        io(0, 16'h0097, 8'h00);
        chk("unmapped", {rd, rv}, {8'hFF, 1'b0});
        io(1, 16'h0103, 8'h01);
        chk("mem en", board_memory_enable, 1'b1);
    endtask
    task automatic t_fb();
        io(0, 16'h0091, 8'h00);
        chk("feedback idle", {rd, rv}, {8'hFE, 1'b1});
        @(posedge clk);
        #1;
        {ioAddr, ioWrData, ioWr} = {16'h0300, 8'h55, 1'b1};
        #2;
        chk("adapter access", boardAccess, 1'b0);
        @(posedge clk);
        #1;
        ioWr = 1'b0;
        // three sync stages, the sync output and the feedback register
        repeat (5) @(posedge clk);
        io(0, 16'h0091, 8'h00);
        chk("feedback", {rd, rv}, {8'hFF, 1'b1});
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #200000;
        miscompares++;
        conclude();
    end
    initial begin
        {rst_n, ioRd, ioWr, extConfigMode, periphSerialEn, periphSerialPrim} = '0;
        {ioAddr, ioWrData} = '0;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        t_reset();
        t_id();
        t_cfg();
        t_ext();
        t_setup();
        t_fb();
        conclude();
    end
endmodule // testbench
